// *** verification/csg_event_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Event unit stand-in for cluster mode
module csg_event_model (
    input  wire logic core_clk,
    input  wire logic stall_req,
    input  wire logic core_sleep,
    output logic      cluster_clock_en
);
    logic stall_q;
    // Stall request taken only at the raw clock edge
    always_ff @(posedge core_clk) begin
        stall_q <= stall_req;
    end
    // Held high while awake; the gate only looks at it during sleep
    assign cluster_clock_en = !(core_sleep && stall_q);
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import csg_pkg::*;
    logic core_clk = 0, reset_n = 1, fetch_enable = 0, wfi_exec = 0;
    logic event_load_instruction = 0, irq_pending = 0, stall = 0, cl_en;
    logic debug_req = 0, debug_pending = 0, debug_mode = 0;
    logic debug_step = 0, trigger_match = 0;
    logic wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat_w = 32'h0000_0000, wb_dat_r;
    wire [1:0] sleep, gclk;
    int err_count = 0, samples_checked = 0, g0 = 0, g1 = 0;
    // Same stimulus reaches both builds; only the first answers the bus
    csg_sleep_unit #(.CLUSTER_MODE(1'b0)) dut_u (.*, .cluster_clock_en(1'b0),
        .core_sleep(sleep[0]), .gated_clk(gclk[0]));
    csg_sleep_unit #(.CLUSTER_MODE(1'b1)) dut1_u (.*, .cluster_clock_en(cl_en),
        .wb_dat_r(), .wb_ack(), .core_sleep(sleep[1]), .gated_clk(gclk[1]));
    csg_event_model ev_u (.core_clk(core_clk), .stall_req(stall),
        .core_sleep(sleep[1]), .cluster_clock_en(cl_en));
    // Raw clock and gated edge counters
    initial forever #5 core_clk = ~core_clk;
    always @(posedge gclk[0]) g0 <= g0 + 1;
    always @(posedge gclk[1]) g1 <= g1 + 1;
    task complete_run;
        if (err_count == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // One classic cycle; read data taken at the ack edge
    task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hF;
        wb_adr <= adr;
        wb_dat_w <= dat;
        do begin
            tick(1);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        if (wb_ack !== 1'b1) begin
            err_count++;
            complete_run();
        end
        if (!we) chk(wb_dat_r, dat);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        tick(1);
    endtask
    // Sampled before the edge lands, so counts never race the gated clock
    task gate(input logic [1:0] exp);
        int s0, s1;
        s0 = g0;
        s1 = g1;
        tick(4);
        chk({30'h0, g1 != s1, g0 != s0}, {30'h0, exp});
    endtask
    task wfi_pulse;
        wfi_exec <= 1'b1;
        tick(1);
        wfi_exec <= 1'b0;
        tick(2);
    endtask
    // Watchdog for a hung run
    initial begin
        repeat (5000) @(posedge core_clk);
        err_count++;
        complete_run();
    end
    initial begin
        // A real falling edge, so the asynchronous reset fires at time zero
        reset_n <= 1'b0;
        gate(2'b00);
        chk({30'h0, sleep}, 32'h0);
        tick(2);
        reset_n <= 1'b1;
        wfi_pulse();
        gate(2'b00);
        chk({30'h0, sleep}, 32'h0);
        fetch_enable <= 1'b1;
        tick(1);
        fetch_enable <= 1'b0;
        gate(2'b11);
        wb(1'b0, CSG_CTRL_OFS, 32'h0000_0001);
        wb(1'b0, CSG_STATUS_OFS, 32'h0000_0006);
        wb(1'b0, 8'h08, 32'h0000_0000);
        wb(1'b1, CSG_CTRL_OFS, 32'h0000_0000);
        wfi_pulse();
        chk({30'h0, sleep}, 32'h0);
        wb(1'b1, CSG_CTRL_OFS, 32'h0000_0001);
        wfi_pulse();
        chk({30'h0, sleep}, 32'h1);
        gate(2'b10);
        irq_pending <= 1'b1;
        tick(2);
        chk({30'h0, sleep}, 32'h0);
        gate(2'b11);
        wfi_pulse();
        chk({30'h0, sleep}, 32'h0);
        irq_pending <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            {trigger_match, debug_step, debug_mode, debug_pending, debug_req} <= 5'h1 << i;
            wfi_pulse();
            chk({30'h0, sleep}, 32'h0);
        end
        {trigger_match, debug_step, debug_mode, debug_pending, debug_req} <= 5'h0;
        event_load_instruction <= 1'b1;
        tick(2);
        chk({30'h0, sleep}, 32'h2);
        gate(2'b11);
        stall <= 1'b1;
        tick(2);
        gate(2'b01);
        stall <= 1'b0;
        gate(2'b11);
        event_load_instruction <= 1'b0;
        tick(2);
        chk({30'h0, sleep}, 32'h0);
        debug_step <= 1'b1;
        event_load_instruction <= 1'b1;
        tick(2);
        chk({30'h0, sleep}, 32'h0);
        // Mid-run reset: gate must close again and wait for a fresh fetch enable
        reset_n <= 1'b0;
        tick(1);
        gate(2'b00);
        chk({30'h0, sleep}, 32'h0);
        reset_n <= 1'b1;
        gate(2'b00);
        fetch_enable <= 1'b1;
        tick(1);
        fetch_enable <= 1'b0;
        gate(2'b11);
        complete_run();
    end
endmodule
`default_nettype wire

// *** verilog/csg_clock_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
// Latch-based gating cell: the enable is captured while the clock is low,
// so a change of enable during the high phase never truncates a pulse.
module csg_clock_gate (
    input  wire logic clk_in,
    input  wire logic enable,
    output logic      clk_gated
);
    logic en_latch;

    // Transparent while clock low, holds while clock high
    always_latch begin
        if (!clk_in) begin
            en_latch <= enable;
        end
    end

    assign clk_gated = clk_in & en_latch;
endmodule
`default_nettype wire

// *** verilog/csg_pkg.sv ***
`default_nettype none
package csg_pkg;
    // Register map, byte addresses on the Wishbone slave
    localparam logic [7:0]  CSG_CTRL_OFS        = 8'h00;
    localparam logic [7:0]  CSG_STATUS_OFS      = 8'h04;
    // Control register fields
    localparam int          CSG_CTRL_WFI_ALLOW  = 0;
    localparam logic        CSG_CTRL_WFI_RST    = 1'b1;
    // Status register fields
    localparam int          CSG_ST_SLEEP        = 0;
    localparam int          CSG_ST_FETCH_SEEN   = 1;
    localparam int          CSG_ST_CLOCK_EN     = 2;
    localparam int          CSG_ST_CLUSTER      = 3;
    // Reset values
    localparam logic [31:0] CSG_DATA_RST        = 32'h0000_0000;
endpackage
`default_nettype wire

// *** verilog/csg_sleep_unit.sv ***
`timescale 1ns/1ps
`default_nettype none
module csg_sleep_unit
    import csg_pkg::*;
#(
    parameter bit CLUSTER_MODE = 1'b0
) (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic        fetch_enable,
    input  wire logic        wfi_exec,
    input  wire logic        event_load_instruction,
    input  wire logic        cluster_clock_en,
    input  wire logic        irq_pending,
    input  wire logic        debug_req,
    input  wire logic        debug_pending,
    input  wire logic        debug_mode,
    input  wire logic        debug_step,
    input  wire logic        trigger_match,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [7:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_dat_w,
    output logic      [31:0] wb_dat_r,
    output logic             wb_ack,
    output logic             core_sleep,
    output logic             gated_clk
);
    logic        fetch_seen_q;
    logic        core_sleep_q;
    logic        core_sleep_d;
    logic        wfi_allow_q;
    logic        wb_ack_q;
    logic [31:0] wb_dat_q;
    logic        debug_block;
    logic        wake_req;
    logic        clock_en;
    logic        bus_req;

    // Any debug activity turns sleep requests away
    assign debug_block = debug_req | debug_pending | debug_mode | debug_step | trigger_match;
    assign wake_req    = irq_pending | debug_req | debug_pending | debug_mode;

    // Fetch enable is sampled once and then held until the next reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fetch_seen_q <= 1'b0;
        end else if (fetch_enable) begin
            fetch_seen_q <= 1'b1;
        end
    end

    // Next sleep state for both modes
    always_comb begin
        core_sleep_d = 1'b0;
        if (CLUSTER_MODE) begin
            // Sleep follows the incomplete event load, no debug in the way
            core_sleep_d = event_load_instruction & ~debug_block;
        end else if (core_sleep_q) begin
            core_sleep_d = ~wake_req;
        end else begin
            // Coincident wake source keeps the instruction a plain no-op
            core_sleep_d = wfi_exec & wfi_allow_q & ~debug_block & ~wake_req;
        end
    end

    // Sleep flag, cleared by reset and held low until fetch is enabled
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_sleep_q <= 1'b0;
        end else begin
            core_sleep_q <= core_sleep_d & fetch_seen_q;
        end
    end

    // Gate enable: reset, fetch enable, the sleep flag and the wake sources (cluster_clock_en in cluster mode).
    // Wake is combinational so the first wake edge is not lost to the gate.
    always_comb begin
        if (CLUSTER_MODE) begin
            clock_en = fetch_seen_q & (~core_sleep_q | cluster_clock_en);
        end else begin
            clock_en = fetch_seen_q & (~core_sleep_q | wake_req);
        end
    end

    // The one and only gate on the raw clock
    csg_clock_gate u_gate (
        .clk_in    (core_clk),
        .enable    (clock_en),
        .clk_gated (gated_clk)
    );

    assign core_sleep = core_sleep_q;

    // Wishbone slave: ack one cycle after the strobe, dropped the next cycle
    assign bus_req = wb_cyc & wb_stb & ~wb_ack_q;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_q <= 1'b0;
        end else begin
            wb_ack_q <= bus_req;
        end
    end

    // Control register; software may veto wait-for-interrupt sleep
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wfi_allow_q <= CSG_CTRL_WFI_RST;
        end else if (bus_req && wb_we && wb_sel[0] && wb_adr == CSG_CTRL_OFS) begin
            wfi_allow_q <= wb_dat_w[CSG_CTRL_WFI_ALLOW];
        end
    end

    // Read data; unmapped addresses answer with zero
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_q <= CSG_DATA_RST;
        end else if (bus_req) begin
            wb_dat_q <= CSG_DATA_RST;
            if (wb_adr == CSG_CTRL_OFS) begin
                wb_dat_q[CSG_CTRL_WFI_ALLOW] <= wfi_allow_q;
            end else if (wb_adr == CSG_STATUS_OFS) begin
                wb_dat_q[CSG_ST_SLEEP]      <= core_sleep_q;
                wb_dat_q[CSG_ST_FETCH_SEEN] <= fetch_seen_q;
                wb_dat_q[CSG_ST_CLOCK_EN]   <= clock_en;
                wb_dat_q[CSG_ST_CLUSTER]    <= CLUSTER_MODE;
            end
        end
    end

    assign wb_ack   = wb_ack_q;
    assign wb_dat_r = wb_dat_q;

    // Checks on the raw clock domain
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    chk_clock_before_fetch: assert property (
        !fetch_seen_q |-> !clock_en && !core_sleep_q)
        else $error("gated clock runs before fetch enable");

    chk_fetch_capture: assert property (
        !fetch_seen_q && fetch_enable |=> fetch_seen_q ##1 fetch_seen_q)
        else $error("fetch enable not captured");

    chk_fetch_sticky: assert property (
        fetch_seen_q |=> fetch_seen_q)
        else $error("fetch enable lost before reset");

    chk_wfi_gates_clock: assert property (
        !CLUSTER_MODE && core_sleep_q && !wake_req |-> !clock_en)
        else $error("clock runs during wfi sleep");

    chk_wfi_debug_nop: assert property (
        !core_sleep_q && (debug_block || CLUSTER_MODE && !event_load_instruction)
        |=> !core_sleep_q)
        else $error("sleep entered despite debug or cluster");

    chk_wake_exit: assert property (
        !CLUSTER_MODE && core_sleep_q && wake_req |-> clock_en ##1 !core_sleep_q)
        else $error("no wake on pending source");

    chk_cluster_gate: assert property (
        CLUSTER_MODE && core_sleep_q |-> clock_en == cluster_clock_en)
        else $error("cluster enable does not drive the gate");

    chk_elw_incomplete: assert property (
        CLUSTER_MODE && (!event_load_instruction || debug_block) |=> !core_sleep_q)
        else $error("event-load sleep without pending load");

    chk_wb_ack_pulse: assert property (
        wb_cyc && wb_stb && !wb_ack_q |=> wb_ack_q ##1 !wb_ack_q)
        else $error("wishbone ack not a single pulse");

    // Reset check drops the default disable so it can look at reset itself
    chk_reset_quiet: assert property (
        @(posedge core_clk) disable iff (1'b0)
        !reset_n |-> !clock_en && !core_sleep_q && !fetch_seen_q)
        else $error("clock or sleep active during reset");

    chk_sleep_needs_fetch: assert property (
        core_sleep_q |-> fetch_seen_q)
        else $error("sleep raised before fetch enable");

    chk_wfi_entry: assert property (
        !CLUSTER_MODE && !core_sleep_q && fetch_seen_q && wfi_exec && wfi_allow_q
        && !debug_block && !wake_req |=> core_sleep_q)
        else $error("wfi did not enter sleep");

    chk_cluster_awake_runs: assert property (
        CLUSTER_MODE && fetch_seen_q && !core_sleep_q |-> clock_en)
        else $error("gate closed while cluster core is awake");

    // Scenarios the bench is expected to reach
    cov_wfi_sleep: cover property (!core_sleep_q ##1 core_sleep_q ##[1:20] !core_sleep_q);
    cov_cluster_stop: cover property (core_sleep_q && !cluster_clock_en);
    cov_status_read: cover property (bus_req && !wb_we && wb_adr == CSG_STATUS_OFS);
    cov_wfi_coincident_wake: cover property (wfi_exec && wake_req && !core_sleep_q);
    cov_debug_nop: cover property (wfi_exec && debug_block);
endmodule
`default_nettype wire
